//--- duty_decoder.sv
// duty cycle decoder: high/low time counting and ratio to signed code
`timescale 1ns/1ps
`default_nettype none
`include "haptic_params.svh"
module duty_decoder #(
  parameter int CW = 20
) (
  input  wire logic   clk,
  input  wire logic   rstN,
  input  wire logic   driveInput,
  duty_link_if.decoder link
);
  import haptic_pkg::*;
  localparam int NW = CW + 8;

  logic            prev_q;
  logic            armed_q;
  logic [CW-1:0]   hiCnt_q;
  logic [CW-1:0]   loCnt_q;
  logic [NW-1:0]   num_q;
  logic [CW:0]     den_q;
  logic [CW:0]     rem_q;
  logic [NW-1:0]   quo_q;
  logic [5:0]      step_q;
  div_state_t      state_q;
  logic [CW+1:0]   remShift;
  logic            rise;

  assign rise = driveInput & ~prev_q;
  assign remShift = {rem_q, num_q[NW-1]};
  assign link.periodTick = rise;
  assign link.inputLevel = driveInput;

  // count high and low time of the running period, saturating
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prev_q  <= 1'b0;
      armed_q <= 1'b0;
      hiCnt_q <= '0;
      loCnt_q <= '0;
    end else begin
      prev_q <= driveInput;
      if (rise) begin
        armed_q <= 1'b1;
        hiCnt_q <= CW'(1);
        loCnt_q <= '0;
      end else if (driveInput && hiCnt_q != '1) begin
        hiCnt_q <= hiCnt_q + CW'(1);
      end else if (!driveInput && loCnt_q != '1) begin
        loCnt_q <= loCnt_q + CW'(1);
      end
    end
  end

  // long division hi*254/(hi+lo), one bit per cycle; a period shorter than
  // the division time is skipped, which only happens far above audio rates
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= DIV_IDLE;
      num_q   <= '0;
      den_q   <= '0;
      rem_q   <= '0;
      quo_q   <= '0;
      step_q  <= '0;
    end else begin
      case (state_q)
        DIV_IDLE: begin
          if (rise && armed_q) begin
            num_q   <= NW'(hiCnt_q) * NW'(`CODE_FULL);
            den_q   <= {1'b0, hiCnt_q} + {1'b0, loCnt_q};
            rem_q   <= '0;
            quo_q   <= '0;
            step_q  <= 6'(NW);
            state_q <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          num_q  <= {num_q[NW-2:0], 1'b0};
          step_q <= step_q - 6'd1;
          if (remShift >= {1'b0, den_q}) begin
            rem_q <= (CW+1)'(remShift - {1'b0, den_q});
            quo_q <= {quo_q[NW-2:0], 1'b1};
          end else begin
            rem_q <= (CW+1)'(remShift);
            quo_q <= {quo_q[NW-2:0], 1'b0};
          end
          if (step_q == 6'd1) begin
            state_q <= DIV_IDLE;
          end
        end
        default: state_q <= DIV_IDLE;
      endcase
    end
  end

  // clamp to 0..254 and shift so that 50% duty gives code 0
  logic [7:0] ratio;
  assign ratio = (quo_q > NW'(`CODE_MAX)) ? `CODE_MAX : quo_q[7:0];

  logic       valid_q;
  level_t     code_q;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      valid_q <= 1'b0;
      code_q  <= '0;
    end else begin
      valid_q <= (state_q == DIV_RUN) && (step_q == 6'd1);  // last quotient bit lands now
      if (valid_q) begin
        code_q <= level_t'(ratio - `CODE_MID);
      end
    end
  end
  logic pub_q;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pub_q <= 1'b0;
    end else begin
      pub_q <= valid_q;
    end
  end
  assign link.codeValid = pub_q;
  assign link.code = code_q;
endmodule
`default_nettype wire

//--- duty_link_if.sv
// carrier between the duty decoder and the drive controller
`timescale 1ns/1ps
`default_nettype none
interface duty_link_if;
  logic                   periodTick;  // one cycle at each input rising edge
  logic                   inputLevel;  // drive input, passed through unregistered
  logic                   codeValid;   // one cycle when a decoded code is ready
  haptic_pkg::level_t     code;        // decoded signed level code
  modport decoder (output periodTick, output inputLevel, output codeValid, output code);
  modport control (input periodTick, input inputLevel, input codeValid, input code);
endinterface
`default_nettype wire

//--- haptic_actuator_drive_control_test.sv
// self-checking bench for the haptic drive controller
`timescale 1ns/1ps
`default_nettype none
`include "haptic_params.svh"
module haptic_actuator_drive_control_test;
  import haptic_pkg::*;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, rdErr, irq;
  logic        runPwm, driveInput, slowOscClock, shortCurrentOver, thermalAlarm;
  logic        motorOutGrounded, amplitudeRangeBit;
  logic [7:0]  paddr, highLen, lowLen;
  logic [31:0] pwdata, prdata, rdData;
  logic [3:0]  pstrb, outputGainSetting;
  drive_t      motorDriveLevel;
  int          failures, tests_run;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // short counter width keeps duty decoding quick
  haptic_drive_ctrl #(.CW(12)) haptic_drive_ctrl_inst (
    .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .driveInput, .slowOscClock, .shortCurrentOver, .thermalAlarm,
    .motorDriveLevel, .motorOutGrounded, .outputGainSetting, .amplitudeRangeBit, .irq
  );
  host_pwm_model host_pwm_model_inst (
    .clk, .runPwm, .highLen, .lowLen, .driveInput, .slowOscClock
  );
  ////////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; request held until ready is sampled high
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      summarize();
    end
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hf);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    xfer(1'b0, a, 32'h0, 4'hf);
    check(nm, rdData, exp);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task level(input int exp, input string nm);
    check(nm, 32'(motorDriveLevel), 32'(exp));
  endtask
  task edge_wait(input logic v);
    int n;
    n = 0;
    // let the current phase pass first so that the return follows a real edge
    while (driveInput === v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    while (driveInput !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      failures++;
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(`OFF_CTRL, 32'h0, "ctrl");
    rd(`OFF_AMP, 32'h0, "amp");
    rd(`OFF_QUIET, 32'h0, "quiet");
    rd(`OFF_IRQ_EN, 32'h0, "irq enable");
    rd(8'h20, 32'h0, "unmapped");
    check("unmapped error", rdErr, 1'b1);
    xfer(1'b1, `OFF_GAIN, 32'h5, 4'he);
    rd(`OFF_GAIN, 32'h1, "gain lane0 off");
    check("gain pin reset", outputGainSetting, 4'h1);
    check("off grounded", motorOutGrounded, 1'b1);
    level(0, "off level");
  endtask
  task t_duty;
    wr(`OFF_CTRL, 32'h2);
    highLen <= 8'd75;
    lowLen <= 8'd25;
    runPwm <= 1'b1;
    cyc(500);
    level(63, "erm duty 75");
    rd(`OFF_STATUS, 32'h3f00, "status code");
    highLen <= 8'd20;
    lowLen <= 8'd80;
    wr(`OFF_GAIN, 32'h3);
    cyc(500);
    level(-231, "erm duty 20 gain 3");
    check("gain pin", outputGainSetting, 4'h3);
    highLen <= 8'd50;
    lowLen <= 8'd50;
    cyc(500);
    level(0, "erm duty 50");
  endtask
  task t_lra;
    wr(`OFF_CTRL, 32'h1);
    wr(`OFF_GAIN, 32'h1);
    highLen <= 8'd90;
    lowLen <= 8'd60;
    cyc(600);
    edge_wait(1'b1);
    cyc(45);
    level(25, "lra high phase");
    edge_wait(1'b0);
    cyc(30);
    level(-25, "lra low phase");
    wr(`OFF_AMP, 32'hd8);
    wr(`OFF_CTRL, 32'h5);
    cyc(600);
    edge_wait(1'b1);
    cyc(45);
    level(-40, "lra register");
    // resonant quiet band counts carrier periods; a short period keeps it brief
    highLen <= 8'd16;
    lowLen <= 8'd16;
    wr(`OFF_AMP, 32'h3);
    wr(`OFF_QUIET, 32'h5);
    cyc(15800);
    check("lra before 512", motorOutGrounded, 1'b0);
    cyc(1200);
    check("lra after 512", motorOutGrounded, 1'b1);
    level(0, "lra quiet level");
    wr(`OFF_QUIET, 32'h0);
    wr(`OFF_IRQ_CLR, 32'h4);
  endtask
  // register-driven eccentric motor held in the quiet band
  task t_quiet;
    runPwm <= 1'b0;
    wr(`OFF_CTRL, 32'he);
    wr(`OFF_AMP, 32'h5);
    wr(`OFF_IRQ_EN, 32'h7);
    check("range bit", amplitudeRangeBit, 1'b1);
    wr(`OFF_QUIET, 32'ha);
    cyc(800);
    level(5, "erm register");
    cyc(3040);
    level(5, "quiet before 512");
    cyc(480);
    level(0, "quiet after 512");
    check("quiet irq", irq, 1'b1);
    rd(`OFF_IRQ_STAT, 32'h4, "quiet event");
    rd(`OFF_STATUS, 32'h0504, "quiet status");
    wr(`OFF_IRQ_CLR, 32'h4);
    cyc(2);
    check("quiet irq clear", irq, 1'b0);
    wr(`OFF_AMP, 32'h32);
    cyc(40);
    level(50, "leave quiet");
  endtask
  // short circuit then thermal alarm, each set and removed
  task t_protect;
    for (int i = 0; i < 2; i++) begin
      if (i == 0) shortCurrentOver <= 1'b1;
      else thermalAlarm <= 1'b1;
      cyc(4);
      check("grounded", motorOutGrounded, 1'b1);
      rd(`OFF_STATUS, 32'h3200 | (32'h1 << i), "fault flag");
      check("fault irq", irq, 1'b1);
      shortCurrentOver <= 1'b0;
      thermalAlarm <= 1'b0;
      cyc(4);
      check("released", motorOutGrounded, 1'b0);
      level(50, "resumed");
      wr(`OFF_IRQ_CLR, 32'h1 << i);
      cyc(2);
      check("fault irq clear", irq, 1'b0);
    end
    wr(`OFF_CTRL, 32'h0);
    cyc(4);
    check("disabled grounded", motorOutGrounded, 1'b1);
    level(0, "disabled level");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, runPwm, shortCurrentOver, thermalAlarm, arst_n} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    highLen = 8'd50;
    lowLen = 8'd50;
    failures = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    cyc(3);
    t_reset();
    t_duty();
    t_lra();
    t_quiet();
    t_protect();
    summarize();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire

//--- haptic_drive_checker.sv
// port-level assertions for the haptic drive controller
`timescale 1ns/1ps
`default_nettype none
`include "haptic_params.svh"
module haptic_drive_checker #(
  parameter int CW = 20
) (
  input wire logic                clk,
  input wire logic                arst_n,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  input wire logic                shortCurrentOver,
  input wire logic                thermalAlarm,
  input wire haptic_pkg::drive_t  motorDriveLevel,
  input wire logic                motorOutGrounded,
  input wire logic [3:0]          outputGainSetting,
  input wire logic                amplitudeRangeBit
);
  import haptic_pkg::*;
  // one domain, so clock and reset are given once for all properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered in time");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_in_access: assert property (pslverr |-> pready && psel && penable)
    else $error("error flag outside an answered access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside an answer");
  // a steady over-current must reach the outputs within two cycles
  a_short_grounds: assert property (shortCurrentOver ##1 shortCurrentOver |=> motorOutGrounded)
    else $error("outputs not grounded under over-current");
  a_heat_grounds: assert property (thermalAlarm [*2] |=> motorOutGrounded)
    else $error("outputs not grounded under thermal alarm");
  // full-scale code times largest gain bounds the level
  a_level_bound: assert property (motorDriveLevel <= 12'sd1905 && motorDriveLevel >= -12'sd1905)
    else $error("drive level beyond full scale");
  a_gain_write: assert property ($changed(outputGainSetting) |-> $past(pready && pwrite && paddr == `OFF_GAIN, 2))
    else $error("gain changed without a register write");
  a_range_write: assert property ($changed(amplitudeRangeBit) |-> $past(pready && pwrite && paddr == `OFF_CTRL, 2))
    else $error("range bit changed without a register write");
  c_refused: cover property (pready && pslverr);
  c_short: cover property (shortCurrentOver && motorOutGrounded);
  c_resume: cover property ($fell(motorOutGrounded));
endmodule
bind haptic_drive_ctrl haptic_drive_checker #(.CW(CW)) haptic_drive_checker_inst (
  .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
  .shortCurrentOver, .thermalAlarm, .motorDriveLevel, .motorOutGrounded,
  .outputGainSetting, .amplitudeRangeBit
);
`default_nettype wire

//--- haptic_drive_ctrl.sv
// haptic actuator drive control: apb registers, level select, quiet band, protection
`timescale 1ns/1ps
`default_nettype none
`include "haptic_params.svh"
module haptic_drive_ctrl #(
  parameter int CW = 20
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire logic                driveInput,
  input  wire logic                slowOscClock,
  input  wire logic                shortCurrentOver,
  input  wire logic                thermalAlarm,
  output haptic_pkg::drive_t       motorDriveLevel,
  output logic                     motorOutGrounded,
  output logic [3:0]               outputGainSetting,
  output logic                     amplitudeRangeBit,
  output logic                     irq
);
  import haptic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rstMeta_q;
  logic rstN;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN      <= rstMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // duty decoder
  duty_link_if link ();
  duty_decoder #(
    .CW (CW)
  ) u_duty (
    .clk        (clk),
    .rstN       (rstN),
    .driveInput (driveInput),
    .link       (link.decoder)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers
  load_type_t   loadTypeEnable_q;
  logic         driveSourceSelect_q;
  logic         amplitudeRange_q;
  level_t       hostAmplitudeValue_q;
  logic [6:0]   quietBandSetting_q;
  logic [3:0]   gainSetting_q;
  logic [2:0]   irqStat_q;
  logic [2:0]   irqEn_q;
  logic         shortFlag_q;
  logic         thermal_q;
  logic         quiet_q;
  level_t       levelCode_q;

  logic         access;
  logic         wrEn;
  logic         mapped;
  logic [2:0]   events;
  logic [2:0]   clrBits;

  // access phase completes one cycle after penable rises
  assign access = psel & penable & ~pready;
  assign wrEn   = psel & penable & pready & pwrite;
  always_comb begin
    case (paddr)
      `OFF_CTRL, `OFF_AMP, `OFF_QUIET, `OFF_GAIN,
      `OFF_STATUS, `OFF_IRQ_STAT, `OFF_IRQ_CLR, `OFF_IRQ_EN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // apb answer: one wait state, error on an unmapped address
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= access;
      pslverr <= access & ~mapped;
      prdata  <= '0;
      if (access && !pwrite) begin
        case (paddr)
          `OFF_CTRL:     prdata <= {28'h0, amplitudeRange_q, driveSourceSelect_q,
                                    loadTypeEnable_q};
          `OFF_AMP:      prdata <= {24'h0, hostAmplitudeValue_q};
          `OFF_QUIET:    prdata <= {25'h0, quietBandSetting_q};
          `OFF_GAIN:     prdata <= {28'h0, gainSetting_q};
          `OFF_STATUS:   prdata <= {16'h0, levelCode_q, 5'h0, quiet_q, thermal_q,
                                    shortFlag_q};
          `OFF_IRQ_STAT: prdata <= {29'h0, irqStat_q};
          `OFF_IRQ_EN:   prdata <= {29'h0, irqEn_q};
          default:       prdata <= '0;  // clear register reads as zero
        endcase
      end
    end
  end

  // configuration writes honour byte strobes; only lane 0 holds data
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      {amplitudeRange_q, driveSourceSelect_q, loadTypeEnable_q} <= `RST_CTRL;
      hostAmplitudeValue_q <= `RST_AMP;
      quietBandSetting_q   <= `RST_QUIET;
      gainSetting_q        <= `RST_GAIN;
      irqEn_q              <= `RST_IRQ_EN;
    end else if (wrEn && pstrb[0]) begin
      case (paddr)
        `OFF_CTRL: begin
          loadTypeEnable_q    <= pwdata[`CTRL_TYPE_LSB +: 2];
          driveSourceSelect_q <= pwdata[`CTRL_SRC_BIT];
          amplitudeRange_q    <= pwdata[`CTRL_RNG_BIT];
        end
        `OFF_AMP:    hostAmplitudeValue_q <= level_t'(pwdata[7:0]);
        `OFF_QUIET:  quietBandSetting_q   <= pwdata[6:0];
        `OFF_GAIN:   gainSetting_q        <= pwdata[3:0];
        `OFF_IRQ_EN: irqEn_q              <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // load type decode
  logic enabled;
  logic eccentric;
  logic resonant;
  assign enabled   = (loadTypeEnable_q != 2'b00);
  assign eccentric = (loadTypeEnable_q == LOAD_ECCENTRIC);
  assign resonant  = (loadTypeEnable_q == LOAD_RESONANT);

  ////////////////////////////////////////////////////////////////////////////
  // slow oscillator edge: inputs are synchronous, so one flop finds the edge
  logic slowPrev_q;
  logic slowTick;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      slowPrev_q <= 1'b0;
    end else begin
      slowPrev_q <= slowOscClock;
    end
  end
  assign slowTick = slowOscClock & ~slowPrev_q;

  ////////////////////////////////////////////////////////////////////////////
  // signed level code selection
  // in register mode the eccentric load also expects the drive input grounded
  // and the range bit set by software; neither is enforced here
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      levelCode_q <= '0;
    end else if (!driveSourceSelect_q) begin
      if (link.codeValid) begin
        levelCode_q <= link.code;
      end
    end else if (eccentric) begin
      if (slowTick) begin
        levelCode_q <= hostAmplitudeValue_q;
      end
    end else if (link.periodTick) begin
      levelCode_q <= hostAmplitudeValue_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quiet band: count qualifying ticks while code stays inside the band
  logic       inBand;
  logic       quietTick;
  logic [9:0] quietCnt_q;
  logic [7:0] magnitude;
  assign magnitude = levelCode_q[7] ? 8'(-levelCode_q) : 8'(levelCode_q);
  assign inBand    = (magnitude <= {1'b0, quietBandSetting_q});
  // eccentric register mode counts oscillator cycles, other cases input periods
  assign quietTick = (eccentric && driveSourceSelect_q) ? slowTick : link.periodTick;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      quietCnt_q <= '0;
      quiet_q    <= 1'b0;
    end else if (!inBand || !enabled) begin
      quietCnt_q <= '0;
      quiet_q    <= 1'b0;
    end else if (quietTick) begin
      if (quietCnt_q == `QUIET_HOLD) begin
        quiet_q <= 1'b1;
      end else begin
        quietCnt_q <= quietCnt_q + 10'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection: flags follow their conditions, so drive resumes by itself
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      shortFlag_q <= 1'b0;
      thermal_q   <= 1'b0;
    end else begin
      shortFlag_q <= shortCurrentOver;
      thermal_q   <= thermalAlarm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output drive: code times gain, in steps of 1.135/127 volt
  logic   stopped;
  drive_t envelope;
  assign stopped  = !enabled || shortFlag_q || thermal_q;
  assign envelope = drive_t'(levelCode_q) * drive_t'({1'b0, gainSetting_q});

  // the resonant carrier follows the drive input: positive half while it is high
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      motorDriveLevel  <= '0;
      motorOutGrounded <= 1'b1;
    end else if (stopped || quiet_q) begin
      motorDriveLevel  <= '0;
      motorOutGrounded <= 1'b1;
    end else if (resonant) begin
      motorDriveLevel  <= link.inputLevel ? envelope : drive_t'(-envelope);
      motorOutGrounded <= 1'b0;
    end else if (eccentric) begin
      motorDriveLevel  <= envelope;
      motorOutGrounded <= 1'b0;
    end else begin
      motorDriveLevel  <= '0;  // reserved load type drives nothing
      motorOutGrounded <= 1'b1;
    end
  end

  // analog-facing settings mirrored from their registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      outputGainSetting <= `RST_GAIN;
      amplitudeRangeBit <= 1'b0;
    end else begin
      outputGainSetting <= gainSetting_q;
      amplitudeRangeBit <= amplitudeRange_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: rising edges of short, thermal and quiet set sticky bits
  logic shortPrev_q;
  logic thermalPrev_q;
  logic quietPrev_q;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      shortPrev_q   <= 1'b0;
      thermalPrev_q <= 1'b0;
      quietPrev_q   <= 1'b0;
    end else begin
      shortPrev_q   <= shortFlag_q;
      thermalPrev_q <= thermal_q;
      quietPrev_q   <= quiet_q;
    end
  end
  assign events[`EV_SHORT]   = shortFlag_q & ~shortPrev_q;
  assign events[`EV_THERMAL] = thermal_q & ~thermalPrev_q;
  assign events[`EV_QUIET]   = quiet_q & ~quietPrev_q;
  assign clrBits = (wrEn && pstrb[0] && paddr == `OFF_IRQ_CLR) ? pwdata[2:0] : 3'h0;

  // a new event in the clear cycle survives: set beats clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqStat_q <= '0;
      irq       <= 1'b0;
    end else begin
      irqStat_q <= (irqStat_q & ~clrBits) | events;
      irq       <= |(((irqStat_q & ~clrBits) | events) & irqEn_q);
    end
  end
endmodule
`default_nettype wire

//--- haptic_params.svh
// constants of the haptic actuator drive control block
//
// What this block does
// - drive-source select 0: level code comes from drive input duty cycle.
// - duty mode: new code each input period, 50% is 0, extremes -127/+127.
// - drive-source select 1: level code comes from host amplitude register.
// - eccentric load in register mode: amplitude sampled on slow oscillator.
// - resonant register mode: sampled per input period; host keeps input toggling.
// - load type 10 selects the eccentric-mass motor.
// - load type 01 selects the resonant actuator with alternating carrier.
// - load type 00 disables drive; 01 and 10 enable it, 11 keeps the outputs grounded.
// - eccentric: zero output after over 512 quiet periods or oscillator cycles.
// - resonant: zero envelope after over 512 quiet carrier periods.
// - output amplitude is code/127 times 1.135 V times gain setting.
// - over-current sets short flag, stops drive, grounds both outputs.
// - short condition gone: flag clears and drive resumes by itself.
// - thermal alarm stops drive; drive resumes directly when it clears.
`ifndef HAPTIC_PARAMS_SVH
`define HAPTIC_PARAMS_SVH

// apb byte offsets
`define OFF_CTRL      8'h00
`define OFF_AMP       8'h04
`define OFF_QUIET     8'h08
`define OFF_GAIN      8'h0c
`define OFF_STATUS    8'h10
`define OFF_IRQ_STAT  8'h14
`define OFF_IRQ_CLR   8'h18
`define OFF_IRQ_EN    8'h1c

// control register fields
`define CTRL_TYPE_LSB 0
`define CTRL_SRC_BIT  2
`define CTRL_RNG_BIT  3

// event bits
`define EV_SHORT      0
`define EV_THERMAL    1
`define EV_QUIET      2

// reset values
`define RST_CTRL      4'h0
`define RST_AMP       8'h00
`define RST_QUIET     7'h00
`define RST_GAIN      4'h1
`define RST_IRQ_EN    3'h0

// quiet band hold count and code scale
`define QUIET_HOLD    10'd512
`define CODE_FULL     8'd254
`define CODE_MID      8'd127
`define CODE_MAX      8'd254

`endif

//--- haptic_pkg.sv
// types of the haptic actuator drive control block
package haptic_pkg;
  typedef logic [1:0] load_type_t;
  typedef logic signed [7:0] level_t;
  typedef logic signed [11:0] drive_t;
  typedef enum logic [1:0] {
    LOAD_OFF,
    LOAD_RESONANT,
    LOAD_ECCENTRIC,
    LOAD_RESERVED
  } load_kind_t;
  typedef enum logic {
    DIV_IDLE,
    DIV_RUN
  } div_state_t;
endpackage

//--- host_pwm_model.sv
// host side model: pwm drive input and free slow oscillator
`timescale 1ns/1ps
`default_nettype none
module host_pwm_model (
  input  wire logic       clk,
  input  wire logic       runPwm,
  input  wire logic [7:0] highLen,
  input  wire logic [7:0] lowLen,
  output logic            driveInput,
  output logic            slowOscClock
);
  logic [7:0] phaseQ = 8'h00;
  logic [2:0] oscQ = 3'h0;
  // input held low when stopped, otherwise toggles without pause
  always_ff @(posedge clk) begin
    if (!runPwm) begin
      driveInput <= 1'b0;
      phaseQ <= 8'h00;
    end else if (phaseQ + 8'h01 >= (driveInput ? highLen : lowLen)) begin
      driveInput <= ~driveInput;
      phaseQ <= 8'h00;
    end else begin
      phaseQ <= phaseQ + 8'h01;
    end
  end
  // oscillator ticks every 8 cycles, far faster than real, to keep runs short
  always_ff @(posedge clk) begin
    oscQ <= oscQ + 3'h1;
    slowOscClock <= oscQ[2];
  end
endmodule
`default_nettype wire
